/* rx_status_map.svh */
/*
  Register indices, field positions, reset values and counts of the
  receive status readback bank.
  Assumes it is included by bare name; definitions only.
*/
`ifndef RX_STATUS_MAP_SVH
`define RX_STATUS_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define MP_THR_CFG_IDX  8'h48
`define VIEW_CFG_IDX    8'h62
`define SIG_QUAL_IDX    8'h66
`define SIG_FIELD_IDX   8'h68
`define SERVICE_IDX     8'h6a
`define LEN_LO_IDX      8'h6c
`define LEN_HI_IDX      8'h6e
`define CRC_LO_IDX      8'h70
`define CRC_HI_IDX      8'h72
`define TX_PWR_IDX      8'h74
`define MEAN_PWR_IDX    8'h78
`define IF_GAIN_IDX     8'h7a

// field positions
`define VIEW_SEL_BIT    7
`define SEED_MSB        6
`define MP_THR_MSB      7
`define MP_THR_LSB      5
`define IF_GAIN_MSB     6

// reset values
`define VIEW_CFG_RST    8'h00
`define MP_THR_CFG_RST  8'h00

// counts
`define MP_HISTORY_LEN  15
`define TX_AVG_SAMPLES  7'h40
`define TX_AVG_SHIFT    6

// bus responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

/* rx_status_pkg.sv */
/*
  Types of the receive status readback bank: state encodings and the
  packed state records of both modules.
  Assumes rx_status_map.svh for the widths of the history.
*/
`default_nettype none
`include "rx_status_map.svh"

package rx_status_pkg;

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_RESP = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b01,
    R_DATA = 2'b10
  } rd_state_t;

  // whole state of the bus slave and the register bank
  typedef struct packed {
    wr_state_t  wst;
    logic       awready;
    logic       wready;
    logic       aw_got;
    logic       w_got;
    logic [7:0] widx;
    logic [7:0] wdata;
    logic       wstrb0;
    logic       bvalid;
    logic [1:0] bresp;
    rd_state_t  rst;
    logic       arready;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic [7:0] view_cfg;
    logic [7:0] mp_cfg;
    logic       receive_path_active_d;
    logic [7:0] pkt_q;
    logic [7:0] hdr_q;
  } ctl_state_t;

  // whole state of the metric tracker
  typedef struct packed {
    logic [`MP_HISTORY_LEN-1:0] hist;
    logic [3:0]                 mp_count;
    logic signed [13:0]         acc;
    logic [6:0]                 n;
    logic [7:0]                 tx_avg;
  } trk_state_t;

endpackage

`default_nettype wire

/* rx_metric_if.sv */
/*
  Signals between the register bank and the metric tracker.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface rx_metric_if;
  logic       pkt_end;
  logic [7:0] metric;
  logic [2:0] thr;
  logic [7:0] tx_sample;
  logic       tx_valid;
  logic [3:0] mp_count;
  logic [7:0] tx_avg;

  modport tracker (input pkt_end, metric, thr, tx_sample, tx_valid,
                   output mp_count, tx_avg);
  modport bank    (output pkt_end, metric, thr, tx_sample, tx_valid,
                   input mp_count, tx_avg);
endinterface

`default_nettype wire

/* rx_metric_tracker.sv */
/*
  Keeps the multipath history of the last packets and the average
  of each block of 64 transmit power samples.
  Assumes aclk, synchronous active-low aresetn, inputs on aclk.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_metric_tracker
  import rx_status_pkg::*;
(
  input  wire logic   aclk,
  input  wire logic   aresetn,
  rx_metric_if.tracker mif
);

  trk_state_t st_r;
  trk_state_t st_nxt;

  // population count of the history window
  function automatic logic [3:0] ones(input logic [`MP_HISTORY_LEN-1:0] v);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < `MP_HISTORY_LEN; i++) begin
      c = c + 4'(v[i]);
    end
    return c;
  endfunction

  // history shifts once per packet; the average closes every 64 samples
  always_comb begin
    logic signed [13:0] sum;
    sum = st_r.acc + 14'(signed'(mif.tx_sample));
    st_nxt = st_r;
    if (mif.pkt_end) begin
      // only the threshold's three bits exist, so the metric's top three compare
      st_nxt.hist = {st_r.hist[`MP_HISTORY_LEN-2:0], (mif.metric[7:5] > mif.thr)};
      st_nxt.mp_count = ones(st_nxt.hist);
    end
    if (mif.tx_valid) begin
      if (st_r.n == `TX_AVG_SAMPLES - 7'h01) begin
        st_nxt.tx_avg = sum[13:`TX_AVG_SHIFT];
        st_nxt.acc = 14'sh0;
        st_nxt.n = 7'h00;
      end else begin
        st_nxt.acc = sum;
        st_nxt.n = st_r.n + 7'h01;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mif.mp_count = st_r.mp_count;
  assign mif.tx_avg   = st_r.tx_avg;

endmodule // rx_metric_tracker

`default_nettype wire

/* rx_status_readback_mux.sv */
/*
  Read-only receive status bank with a/b views behind an AXI4-Lite
  slave, plus the view-select and multipath threshold configuration.
  Assumes all status inputs come from receiver logic on aclk.
*/
// Our own choice: the AXI4-Lite slave port.
// What this block does
// - view bit 0 gives b, 1 gives a
// - 66h: noise A, else carrier loop quality
// - 68h: noise B, else signal field
// - 6Ah: I DC offset, else service field
// - 6Ch: Q DC offset, else length low
// - 6Eh: multipath metric, else length high
// - 70h a: multipath count of last 15
// - 70h/72h b: header CRC low, high
// - 72h a: packet quality, read after receive
// - 74h: 64-sample transmit power average
// - 78h a: header quality, read after receive
// - 78h b: mean receive power in dB
// - 7Ah: IF gain word, bit 7 empty
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_map.svh"

module rx_status_readback_mux
  import rx_status_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // receiver status
  input  wire logic [7:0]  first_antenna_noise_level,
  input  wire logic [7:0]  second_antenna_noise_level,
  input  wire logic [7:0]  carrier_snr_quality,
  input  wire logic [7:0]  rx_signal_field,
  input  wire logic [7:0]  rx_service_field,
  input  wire logic [15:0] rx_length_field,
  input  wire logic [7:0]  dc_offset_i,
  input  wire logic [7:0]  dc_offset_q,
  input  wire logic [7:0]  multipath_metric,
  input  wire logic        packet_end,
  input  wire logic [15:0] header_crc,
  input  wire logic [7:0]  packet_quality,
  input  wire logic [7:0]  header_quality,
  input  wire logic [7:0]  tx_power_sample,
  input  wire logic        tx_sample_valid,
  input  wire logic [7:0]  rx_mean_power,
  input  wire logic [6:0]  if_gain_word,
  input  wire logic        receive_path_active,
  // configuration towards the receiver
  output logic [6:0]       short_preamble_seed,
  output logic [7:0]       multipath_threshold_config
);

  ////////////////////////////////////////////////////////////////////
  // state and reset value

  localparam ctl_state_t CTL_RST = '{
    wst: W_IDLE, awready: 1'b1, wready: 1'b1, aw_got: 1'b0,
    w_got: 1'b0, widx: 8'h00, wdata: 8'h00, wstrb0: 1'b0,
    bvalid: 1'b0, bresp: `RESP_OKAY, rst: R_IDLE, arready: 1'b1,
    rvalid: 1'b0, rdata: 8'h00, rresp: `RESP_OKAY,
    view_cfg: `VIEW_CFG_RST, mp_cfg: `MP_THR_CFG_RST,
    receive_path_active_d: 1'b0, pkt_q: 8'h00, hdr_q: 8'h00
  };

  ctl_state_t  st_r;
  ctl_state_t  st_nxt;
  rx_metric_if mif ();

  logic       view_a;
  logic [7:0] ar_idx;
  logic       ar_fire;

  // the view bit selects a or b for every read-only register except 74h and 7Ah
  assign view_a  = st_r.view_cfg[`VIEW_SEL_BIT];
  assign ar_idx  = s_axi_araddr[9:2];
  assign ar_fire = s_axi_arvalid && st_r.arready;

  // status indices that ignore writes
  function automatic logic is_status(input logic [7:0] idx);
    case (idx)
      `SIG_QUAL_IDX, `SIG_FIELD_IDX, `SERVICE_IDX, `LEN_LO_IDX,
      `LEN_HI_IDX, `CRC_LO_IDX, `CRC_HI_IDX, `TX_PWR_IDX,
      `MEAN_PWR_IDX, `IF_GAIN_IDX: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // metric tracker hookup

  assign mif.pkt_end   = packet_end;
  assign mif.metric    = multipath_metric;
  assign mif.thr       = st_r.mp_cfg[`MP_THR_MSB:`MP_THR_LSB];
  assign mif.tx_sample = tx_power_sample;
  assign mif.tx_valid  = tx_sample_valid;

  rx_metric_tracker u_tracker (
    .aclk    (aclk),
    .aresetn (aresetn),
    .mif     (mif.tracker)
  );

  ////////////////////////////////////////////////////////////////////
  // next state: write channel, read channel, quality latches

  always_comb begin
    logic [7:0] rd_val;
    logic       rd_hit;
    rd_val = 8'h00;
    rd_hit = 1'b1;
    st_nxt = st_r;

    // write: address and data taken in either order
    unique case (st_r.wst)
      W_IDLE: begin
        if (s_axi_awvalid && st_r.awready) begin
          st_nxt.aw_got  = 1'b1;
          st_nxt.awready = 1'b0;
          st_nxt.widx    = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && st_r.wready) begin
          st_nxt.w_got  = 1'b1;
          st_nxt.wready = 1'b0;
          st_nxt.wdata  = s_axi_wdata[7:0];
          st_nxt.wstrb0 = s_axi_wstrb[0];
        end
        // commit one cycle after both halves are held
        if (st_r.aw_got && st_r.w_got) begin
          st_nxt.aw_got = 1'b0;
          st_nxt.w_got  = 1'b0;
          st_nxt.bvalid = 1'b1;
          st_nxt.bresp  = `RESP_OKAY;
          st_nxt.wst    = W_RESP;
          if (st_r.widx == `VIEW_CFG_IDX) begin
            if (st_r.wstrb0) begin
              st_nxt.view_cfg = st_r.wdata;
            end
          end else if (st_r.widx == `MP_THR_CFG_IDX) begin
            if (st_r.wstrb0) begin
              st_nxt.mp_cfg = st_r.wdata;
            end
          end else if (!is_status(st_r.widx)) begin
            st_nxt.bresp = `RESP_SLVERR;
          end
          // status writes answer okay and store nothing
        end
      end
      W_RESP: begin
        if (s_axi_bready) begin
          st_nxt.bvalid  = 1'b0;
          st_nxt.awready = 1'b1;
          st_nxt.wready  = 1'b1;
          st_nxt.wst     = W_IDLE;
        end
      end
    endcase

    // read mux; the upper address bits must be clear to hit
    case (ar_idx)
      `MP_THR_CFG_IDX: rd_val = st_r.mp_cfg;
      `VIEW_CFG_IDX:   rd_val = st_r.view_cfg;
      `SIG_QUAL_IDX:   rd_val = view_a ? first_antenna_noise_level
                                       : carrier_snr_quality;
      `SIG_FIELD_IDX:  rd_val = view_a ? second_antenna_noise_level
                                       : rx_signal_field;
      `SERVICE_IDX:    rd_val = view_a ? dc_offset_i
                                       : rx_service_field;
      `LEN_LO_IDX:     rd_val = view_a ? dc_offset_q
                                       : rx_length_field[7:0];
      `LEN_HI_IDX:     rd_val = view_a ? multipath_metric
                                       : rx_length_field[15:8];
      `CRC_LO_IDX:     rd_val = view_a ? {4'h0, mif.mp_count}
                                       : header_crc[7:0];
      `CRC_HI_IDX:     rd_val = view_a ? st_r.pkt_q
                                       : header_crc[15:8];
      `TX_PWR_IDX:     rd_val = mif.tx_avg;
      `MEAN_PWR_IDX:   rd_val = view_a ? st_r.hdr_q
                                       : rx_mean_power;
      `IF_GAIN_IDX:    rd_val = {1'b0, if_gain_word};
      default:         rd_hit = 1'b0;
    endcase
    if (s_axi_araddr[11:10] != 2'b00) begin
      rd_hit = 1'b0;
    end

    // read: value sampled when the address is taken
    unique case (st_r.rst)
      R_IDLE: begin
        if (ar_fire) begin
          st_nxt.arready = 1'b0;
          st_nxt.rvalid  = 1'b1;
          st_nxt.rdata   = rd_hit ? rd_val : 8'h00;
          st_nxt.rresp   = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
          st_nxt.rst     = R_DATA;
        end
      end
      R_DATA: begin
        if (s_axi_rready) begin
          st_nxt.rvalid  = 1'b0;
          st_nxt.arready = 1'b1;
          st_nxt.rst     = R_IDLE;
        end
      end
    endcase

    // quality metrics freeze when reception ends, so a late read is stable
    st_nxt.receive_path_active_d = receive_path_active;
    if (st_r.receive_path_active_d && !receive_path_active) begin
      st_nxt.pkt_q = packet_quality;
      st_nxt.hdr_q = header_quality;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= CTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from the state record
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = {24'h0, st_r.rdata};
  assign s_axi_rresp   = st_r.rresp;
  assign short_preamble_seed        = st_r.view_cfg[`SEED_MSB:0];
  assign multipath_threshold_config = st_r.mp_cfg;

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_a(logic [7:0] i);
    ar_fire && ar_idx == i && s_axi_araddr[11:10] == 2'b00 && view_a;
  endsequence

  sequence s_rd_b(logic [7:0] i);
    ar_fire && ar_idx == i && s_axi_araddr[11:10] == 2'b00 && !view_a;
  endsequence

  property p_view_b_snr;
    s_rd_b(`SIG_QUAL_IDX) |=>
      s_axi_rvalid && s_axi_rdata == {24'h0, $past(carrier_snr_quality)};
  endproperty
  a_view_b_snr: assert property (p_view_b_snr)
    else $error("view b at 66h lost carrier quality");

  property p_noise_a;
    s_rd_a(`SIG_QUAL_IDX) |=>
      s_axi_rdata[7:0] == $past(first_antenna_noise_level);
  endproperty
  a_noise_a: assert property (p_noise_a)
    else $error("view a at 66h lost noise level A");

  property p_signal_field;
    s_rd_b(`SIG_FIELD_IDX) |=> s_axi_rdata[7:0] == $past(rx_signal_field);
  endproperty
  a_signal_field: assert property (p_signal_field)
    else $error("view b at 68h lost signal field");

  property p_i_offset;
    s_rd_a(`SERVICE_IDX) |=> s_axi_rdata[7:0] == $past(dc_offset_i);
  endproperty
  a_i_offset: assert property (p_i_offset)
    else $error("view a at 6Ah lost I offset");

  property p_q_offset;
    s_rd_a(`LEN_LO_IDX) |=> s_axi_rdata[7:0] == $past(dc_offset_q);
  endproperty
  a_q_offset: assert property (p_q_offset)
    else $error("view a at 6Ch lost Q offset");

  property p_len_high;
    s_rd_b(`LEN_HI_IDX) |=>
      s_axi_rdata[7:0] == $past(rx_length_field[15:8]);
  endproperty
  a_len_high: assert property (p_len_high)
    else $error("view b at 6Eh lost length high byte");

  property p_mp_count;
    s_rd_a(`CRC_LO_IDX) |=> s_axi_rdata == {28'h0, $past(mif.mp_count)};
  endproperty
  a_mp_count: assert property (p_mp_count)
    else $error("view a at 70h lost multipath count");

  property p_crc_high;
    s_rd_b(`CRC_HI_IDX) |=> s_axi_rdata[7:0] == $past(header_crc[15:8]);
  endproperty
  a_crc_high: assert property (p_crc_high)
    else $error("view b at 72h lost crc high byte");

  property p_pkt_quality;
    $fell(receive_path_active) |=> st_r.pkt_q == $past(packet_quality);
  endproperty
  a_pkt_quality: assert property (p_pkt_quality)
    else $error("packet quality not frozen at end of reception");

  property p_pkt_read;
    s_rd_a(`CRC_HI_IDX) |=> s_axi_rdata[7:0] == $past(st_r.pkt_q);
  endproperty
  a_pkt_read: assert property (p_pkt_read)
    else $error("view a at 72h lost frozen packet quality");

  property p_tx_power;
    ar_fire && ar_idx == `TX_PWR_IDX && s_axi_araddr[11:10] == 2'b00 |=>
      s_axi_rdata[7:0] == $past(mif.tx_avg);
  endproperty
  a_tx_power: assert property (p_tx_power)
    else $error("74h lost transmit power average");

  property p_hdr_quality;
    receive_path_active && $past(receive_path_active) |-> $stable(st_r.hdr_q);
  endproperty
  a_hdr_quality: assert property (p_hdr_quality)
    else $error("header quality moved during reception");

  property p_mean_power;
    s_rd_b(`MEAN_PWR_IDX) |=> s_axi_rdata[7:0] == $past(rx_mean_power);
  endproperty
  a_mean_power: assert property (p_mean_power)
    else $error("view b at 78h lost mean power");

  property p_if_gain;
    ar_fire && ar_idx == `IF_GAIN_IDX && s_axi_araddr[11:10] == 2'b00 |=>
      s_axi_rdata == {25'h0, $past(if_gain_word)};
  endproperty
  a_if_gain: assert property (p_if_gain)
    else $error("7Ah lost gain word or bit 7 set");

  property p_ro_write;
    $rose(st_r.bvalid) && is_status(st_r.widx) |->
      $stable(st_r.view_cfg) && $stable(st_r.mp_cfg) && st_r.bresp == `RESP_OKAY;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("write to a status address changed state");

  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read answer dropped before rready");

endmodule // rx_status_readback_mux

`default_nettype wire

/* rx_status_readback_mux_bench.sv */
/*
  Self-checking bench of the receive status readback bank: AXI4-Lite master tasks,
  a reference model of both views, multipath, transmit power and quality stimulus.
  Assumes the design files and rx_status_map.svh are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rx_status_map.svh"

module rx_status_readback_mux_bench;
  logic        aclk, aresetn;
  logic [11:0] awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  noise_a, noise_b, snr, sig_f, svc_f, dci, dcq, mp_m, pq, hq, txs, mean_p;
  logic [15:0] len_f, crc;
  logic [6:0]  ifg, seed;
  logic        pkt_end, tx_v, rx_act;
  logic [7:0]  thr_out, thr, v, e, ix;
  int          n_errors, n_checks, sum, tx_avg, mp_cnt, pq_l, hq_l;
  bit          hist[$];
  logic [7:0]  idx_tab [10] = '{8'h66, 8'h68, 8'h6a, 8'h6c, 8'h6e, 8'h70, 8'h72, 8'h74, 8'h78, 8'h7a};

  rx_status_readback_mux dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .first_antenna_noise_level(noise_a), .second_antenna_noise_level(noise_b),
    .carrier_snr_quality(snr), .rx_signal_field(sig_f), .rx_service_field(svc_f),
    .rx_length_field(len_f), .dc_offset_i(dci), .dc_offset_q(dcq), .multipath_metric(mp_m),
    .packet_end(pkt_end), .header_crc(crc), .packet_quality(pq), .header_quality(hq),
    .tx_power_sample(txs), .tx_sample_valid(tx_v), .rx_mean_power(mean_p), .if_gain_word(ifg),
    .receive_path_active(rx_act), .short_preamble_seed(seed), .multipath_threshold_config(thr_out)
  );

  // 40 MHz clock
  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // compare, count, and close the run
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results;
    if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // bus reads: rready is raised with arvalid so the answer is never missed
  task automatic rd(input logic [11:0] a, output logic [31:0] dat, output logic [1:0] rs);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    dat = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // bus writes: address and data released each at its own acceptance
  task automatic wr(input logic [11:0] a, input logic [7:0] dv, input logic [3:0] st, output logic [1:0] rs);
    bit ga, gw;
    ga = 0;
    gw = 0;
    @(posedge aclk);
    awaddr <= a; wdata <= {24'h0, dv}; wstrb <= st;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin ga = 1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin gw = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // new levels on every plain status input
  task automatic rand_in;
    @(posedge aclk);
    {noise_a, noise_b, snr, sig_f} <= $urandom;
    {svc_f, dci, dcq, mp_m} <= $urandom;
    {pq, hq, mean_p, ifg} <= 31'($urandom);
    {len_f, crc} <= $urandom;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reference model of one status byte in the chosen view
  function automatic logic [7:0] exp_st(logic [7:0] i, bit va);
    case (i)
      `SIG_QUAL_IDX:  return va ? noise_a : snr;
      `SIG_FIELD_IDX: return va ? noise_b : sig_f;
      `SERVICE_IDX:   return va ? dci : svc_f;
      `LEN_LO_IDX:    return va ? dcq : len_f[7:0];
      `LEN_HI_IDX:    return va ? mp_m : len_f[15:8];
      `CRC_LO_IDX:    return va ? 8'(mp_cnt) : crc[7:0];
      `CRC_HI_IDX:    return va ? 8'(pq_l) : crc[15:8];
      `TX_PWR_IDX:    return 8'(tx_avg);
      `MEAN_PWR_IDX:  return va ? 8'(hq_l) : mean_p;
      default:        return {1'b0, ifg};
    endcase
  endfunction

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    results;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    aresetn = 1'b0; awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    {noise_a, noise_b, snr, sig_f, svc_f, dci, dcq, mp_m} = '0;
    {pq, hq, txs, mean_p, len_f, crc, ifg} = '0;
    pkt_end = 0; tx_v = 0; rx_act = 0;
    void'($urandom(60));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // threshold config, plus a write with no byte strobe that must not land
    thr = 8'($urandom);
    wr(12'h120, thr, 4'h1, r);
    wr(12'h120, ~thr, 4'h0, r);
    rd(12'h120, d, r);
    chk("thr_read", {24'h0, thr}, d);
    chk("thr_out", {24'h0, thr}, {24'h0, thr_out});
    // 20 packets so the 15-deep window has to slide
    for (int k = 0; k < 20; k++) begin
      v = 8'($urandom);
      @(posedge aclk);
      mp_m <= v;
      pkt_end <= 1'b1;
      hist.push_back(v[7:5] > thr[7:5]);
      if (hist.size() > `MP_HISTORY_LEN) void'(hist.pop_front());
      @(posedge aclk);
      pkt_end <= 1'b0;
    end
    mp_cnt = 0;
    foreach (hist[k]) mp_cnt += hist[k];
    // 64 back-to-back samples, then 10 more that must not yet change the average
    sum = 0;
    for (int k = 0; k < 74; k++) begin
      v = 8'($urandom);
      @(posedge aclk);
      txs <= v;
      tx_v <= 1'b1;
      if (k < 64) sum += $signed(v);
    end
    @(posedge aclk);
    tx_v <= 1'b0;
    tx_avg = sum >>> 6;
    // qualities freeze when reception ends; later input changes must not show
    @(posedge aclk);
    rx_act <= 1'b1;
    pq <= 8'($urandom);
    hq <= 8'($urandom);
    repeat (3) @(posedge aclk);
    rx_act <= 1'b0;
    pq_l = pq;
    hq_l = hq;
    repeat (2) @(posedge aclk);
    // writes to status addresses answer okay and change nothing
    for (int i = 0; i < 10; i++) begin
      wr({2'b00, idx_tab[i], 2'b00}, 8'($urandom), 4'hf, r);
      chk("status_write_resp", {30'h0, `RESP_OKAY}, {30'h0, r});
    end
    chk("thr_kept", {24'h0, thr}, {24'h0, thr_out});
    // every status byte in view b, then view a
    for (int vw = 0; vw < 2; vw++) begin
      rand_in();
      v = {vw[0], 7'($urandom)};
      wr(12'h188, v, 4'h1, r);
      chk("seed_out", {25'h0, v[6:0]}, {25'h0, seed});
      for (int i = 0; i < 10; i++) begin
        ix = idx_tab[i];
        rd({2'b00, ix, 2'b00}, d, r);
        e = exp_st(ix, vw[0]);
        chk("status_resp", {30'h0, `RESP_OKAY}, {30'h0, r});
        if (ix == `IF_GAIN_IDX) chk("if_gain", {25'h0, e[6:0]}, {25'h0, d[6:0]});
        else chk("status_byte", {24'h0, e}, d);
      end
    end
    // unmapped index and out-of-range upper address bits
    rd(12'h004, d, r);
    chk("unmapped_read_resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("unmapped_read_data", 32'h0, d);
    rd(12'h998, d, r);
    chk("high_read_resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("high_read_data", 32'h0, d);
    wr(12'h004, 8'h5a, 4'hf, r);
    chk("unmapped_write", {30'h0, `RESP_SLVERR}, {30'h0, r});
    results;
  end
endmodule // rx_status_readback_mux_bench

`default_nettype wire
